// File: logic/eap_codec.sv
// aiding packet payload decoder, stored-payload reader and running-time source
//
// Behaviour
// - type 44: 60 bytes, fp64 position, fp32 NED velocity
// - type 44: six fp32 deviations at 36..56
// - type 45: 36 bytes, fp64 position, fp32 deviations
// - type 46: 24 bytes, velocities then deviations
// - type 47: 16 or 24 bytes, body velocities
// - short type 47 shares X deviation across axes
// - type 48: 8 bytes, heading and deviation
// - type 49: read-only seconds and microseconds
// - running time restarts from zero at power on
`timescale 1ns/1ns
`include "eap_map.svh"
module eap_codec
  import eap_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic rxStart,
  input wire logic [7:0] rxId,
  input wire logic [7:0] rxLen,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxDrop,
  output logic fieldValid,
  output logic [7:0] fieldPkt,
  output logic [3:0] fieldIdx,
  output logic [63:0] fieldData,
  output logic fieldWide,
  input wire logic reqValid,
  input wire logic [7:0] reqId,
  output logic reqReady,
  output logic reqNak,
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic txReady,
  output logic [31:0] runSec,
  output logic [31:0] runUsec
);
  localparam int unsigned UsCycles = `EAP_TICK_NS / `EAP_CLK_NS;

  function automatic logic [7:0] def_len(input logic [7:0] id);
    case (id)
      `EAP_ID_POSVEL: def_len = `EAP_LEN_POSVEL;
      `EAP_ID_POS: def_len = `EAP_LEN_POS;
      `EAP_ID_VEL: def_len = `EAP_LEN_VEL;
      `EAP_ID_BODYVEL: def_len = `EAP_LEN_BODY_SHORT;
      `EAP_ID_HEADING: def_len = `EAP_LEN_HEADING;
      `EAP_ID_RUNTIME: def_len = `EAP_LEN_RUNTIME;
      default: def_len = 8'h00;
    endcase
  endfunction : def_len

  function automatic logic [7:0] base_of(input logic [7:0] id);
    case (id)
      `EAP_ID_POS: base_of = `EAP_BASE_POS;
      `EAP_ID_VEL: base_of = `EAP_BASE_VEL;
      `EAP_ID_BODYVEL: base_of = `EAP_BASE_BODYVEL;
      `EAP_ID_HEADING: base_of = `EAP_BASE_HEADING;
      default: base_of = `EAP_BASE_POSVEL;
    endcase
  endfunction : base_of

  function automatic logic [3:0] field_cnt(input logic [7:0] id);
    case (id)
      `EAP_ID_POSVEL: field_cnt = `EAP_NF_POSVEL;
      `EAP_ID_HEADING: field_cnt = `EAP_NF_HEADING;
      default: field_cnt = `EAP_NF_SIX;
    endcase
  endfunction : field_cnt

  // position packets lead with three 8-byte fields
  function automatic logic has_wide(input logic [7:0] id, input logic [3:0] idx);
    has_wide = (id == `EAP_ID_POSVEL || id == `EAP_ID_POS) && idx < `EAP_WIDE_FIELDS;
  endfunction : has_wide

  function automatic logic [7:0] field_off(input logic [7:0] id, input logic [3:0] idx, input logic shortBody);
    if (has_wide(id, idx)) begin
      field_off = {1'b0, idx, 3'b000};
    end else if (id == `EAP_ID_POSVEL || id == `EAP_ID_POS) begin
      field_off = 8'(`EAP_WIDE_AREA + {2'b00, idx - `EAP_WIDE_FIELDS, 2'b00});
    end else if (id == `EAP_ID_BODYVEL && shortBody && idx >= `EAP_BODY_SHARED_IDX) begin
      field_off = `EAP_BODY_SHARED_SD;
    end else begin
      field_off = {2'b00, idx, 2'b00};
    end
  endfunction : field_off

  eap_state_t state;
  eap_state_t next_state;
  logic [7:0] curId;
  logic [7:0] curLen;
  logic [7:0] cnt;
  logic [3:0] idx;
  logic [3:0] bc;
  logic [63:0] acc;
  logic [4:0] written;
  logic [7:0] bodyLen;
  logic [63:0] snap;
  logic isTime;
  logic [4:0] div;
  logic [19:0] usec;
  logic [31:0] sec;
  logic [7:0] memRd;

  wire logic [7:0] rxSlot = 8'(rxId - `EAP_ID_POSVEL);
  wire logic [7:0] reqSlot = 8'(reqId - `EAP_ID_POSVEL);
  wire logic rxKnown = rxId >= `EAP_ID_POSVEL && rxId <= `EAP_ID_HEADING;
  wire logic reqKnown = reqId >= `EAP_ID_POSVEL && reqId <= `EAP_ID_HEADING;
  wire logic rxLenOk = rxKnown && (rxLen == def_len(rxId) ||
    (rxId == `EAP_ID_BODYVEL && rxLen == `EAP_LEN_BODY_LONG));
  wire logic takeRx = state == S_IDLE && rxStart && rxLenOk;
  wire logic dropRx = rxStart && (state == S_RX || (state == S_IDLE && !rxLenOk));
  wire logic takeReq = state == S_IDLE && !rxStart && reqValid;
  wire logic reqTime = reqId == `EAP_ID_RUNTIME;
  wire logic reqStored = reqKnown && written[reqSlot[2:0]];
  wire logic rxByte = state == S_RX && rxValid && !rxStart;
  wire logic rxDone = rxByte && cnt == 8'(curLen - 8'h01);
  wire logic shortBody = bodyLen == `EAP_LEN_BODY_SHORT;
  wire logic [3:0] fw = has_wide(curId, idx) ? 4'h8 : 4'h4;
  wire logic [7:0] fOff = field_off(curId, idx, shortBody);
  wire logic decLast = state == S_DEC && bc == fw;
  wire logic decEnd = decLast && idx == 4'(field_cnt(curId) - 4'h1);
  wire logic [2:0] putPos = 3'(bc - 4'h1);
  wire logic txEnd = state == S_TXW && txReady && cnt == 8'(curLen - 8'h01);
  wire logic [7:0] memWaddr = 8'(base_of(curId) + cnt);
  wire logic [7:0] memRaddr = 8'(base_of(curId) + (state == S_DEC ? 8'(fOff + {4'h0, bc}) : cnt));
  wire logic tick = div == 5'(UsCycles - 1);
  wire logic secWrap = tick && usec == `EAP_USEC_MAX;

  // little-endian assembly of the byte that just left the store
  function automatic logic [63:0] put_byte(input logic [63:0] a, input logic [2:0] pos, input logic [7:0] b);
    logic [63:0] r;
    r = a;
    r[{pos, 3'b000} +: 8] = b;
    put_byte = r;
  endfunction : put_byte

  wire logic [63:0] nextAcc = put_byte(acc, putPos, memRd);

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (takeRx) begin
          next_state = S_RX;
        end else if (takeReq && (reqTime || reqStored)) begin
          next_state = S_TXF;
        end
      end
      S_RX: begin
        if (rxStart) begin
          next_state = S_IDLE;
        end else if (rxDone) begin
          next_state = S_DEC;
        end
      end
      S_DEC: next_state = decEnd ? S_IDLE : S_DEC;
      S_TXF: next_state = S_TXL;
      S_TXL: next_state = S_TXW;
      S_TXW: begin
        if (txEnd) begin
          next_state = S_IDLE;
        end else if (txReady) begin
          next_state = S_TXF;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  eap_mem #(.AW(AW), .DW(8)) u_mem (
    .clk(core_clk),
    .wrEn(rxByte),
    .wrAddr(memWaddr),
    .wrData(rxData),
    .rdAddr(memRaddr),
    .rdData(memRd)
  );

  // running time from power on
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div <= 5'h00;
      usec <= 20'h0_0000;
      sec <= 32'h0000_0000;
    end else begin
      div <= tick ? 5'h00 : 5'(div + 5'h01);
      if (tick) begin
        usec <= secWrap ? 20'h0_0000 : 20'(usec + 20'h0_0001);
      end
      if (secWrap) begin
        sec <= 32'(sec + 32'h0000_0001);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      runSec <= 32'h0000_0000;
      runUsec <= 32'h0000_0000;
    end else begin
      runSec <= sec;
      runUsec <= {12'h000, usec};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      reqReady <= 1'b0;
      curId <= 8'h00;
      curLen <= 8'h00;
      cnt <= 8'h00;
      written <= 5'h00;
      bodyLen <= `EAP_LEN_BODY_SHORT;
      isTime <= 1'b0;
      snap <= 64'h0000_0000_0000_0000;
      rxDrop <= 1'b0;
      reqNak <= 1'b0;
    end else begin
      state <= next_state;
      reqReady <= next_state == S_IDLE;
      rxDrop <= dropRx;
      reqNak <= takeReq && !reqTime && !reqStored;
      if (takeRx) begin
        curId <= rxId;
        curLen <= rxLen;
        cnt <= 8'h00;
        written[rxSlot[2:0]] <= 1'b0;
        if (rxId == `EAP_ID_BODYVEL) begin
          bodyLen <= rxLen;
        end
      end else if (takeReq && (reqTime || reqStored)) begin
        curId <= reqId;
        curLen <= reqTime ? `EAP_LEN_RUNTIME : (reqId == `EAP_ID_BODYVEL ? bodyLen : def_len(reqId));
        cnt <= 8'h00;
        isTime <= reqTime;
        snap <= {runUsec, runSec};
      end else if (rxDone) begin
        written[curId[2:0] - 3'(`EAP_ID_POSVEL)] <= 1'b1;
      end else if (rxByte || (state == S_TXW && txReady && !txEnd)) begin
        cnt <= 8'(cnt + 8'h01);
      end
    end
  end

  // field walk over the stored payload
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idx <= 4'h0;
      bc <= 4'h0;
      acc <= 64'h0000_0000_0000_0000;
      fieldValid <= 1'b0;
      fieldPkt <= 8'h00;
      fieldIdx <= 4'h0;
      fieldData <= 64'h0000_0000_0000_0000;
      fieldWide <= 1'b0;
    end else begin
      fieldValid <= decLast;
      if (state != S_DEC) begin
        idx <= 4'h0;
        bc <= 4'h0;
        acc <= 64'h0000_0000_0000_0000;
      end else if (decLast) begin
        fieldPkt <= curId;
        fieldIdx <= idx;
        fieldData <= nextAcc;
        fieldWide <= fw == 4'h8;
        idx <= 4'(idx + 4'h1);
        bc <= 4'h0;
        acc <= 64'h0000_0000_0000_0000;
      end else begin
        if (bc != 4'h0) begin
          acc <= nextAcc;
        end
        bc <= 4'(bc + 4'h1);
      end
    end
  end

  // read answer, one byte per handshake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txValid <= 1'b0;
      txData <= 8'h00;
      txLast <= 1'b0;
    end else if (state == S_TXL) begin
      txValid <= 1'b1;
      txData <= isTime ? snap[{cnt[2:0], 3'b000} +: 8] : memRd;
      txLast <= cnt == 8'(curLen - 8'h01);
    end else if (state == S_TXW && txReady) begin
      txValid <= 1'b0;
      txLast <= 1'b0;
    end
  end
endmodule : eap_codec

// File: common/eap_map.svh
// offsets, lengths, ids, field counts and timing counts of the aiding packet codec
`ifndef EAP_MAP_SVH
`define EAP_MAP_SVH

`define EAP_ID_POSVEL 8'h2C
`define EAP_ID_POS 8'h2D
`define EAP_ID_VEL 8'h2E
`define EAP_ID_BODYVEL 8'h2F
`define EAP_ID_HEADING 8'h30
`define EAP_ID_RUNTIME 8'h31

`define EAP_LEN_POSVEL 8'h3C
`define EAP_LEN_POS 8'h24
`define EAP_LEN_VEL 8'h18
`define EAP_LEN_BODY_SHORT 8'h10
`define EAP_LEN_BODY_LONG 8'h18
`define EAP_LEN_HEADING 8'h08
`define EAP_LEN_RUNTIME 8'h08

`define EAP_BASE_POSVEL 8'h00
`define EAP_BASE_POS 8'h3C
`define EAP_BASE_VEL 8'h60
`define EAP_BASE_BODYVEL 8'h78
`define EAP_BASE_HEADING 8'h90

`define EAP_NF_POSVEL 4'hC
`define EAP_NF_SIX 4'h6
`define EAP_NF_HEADING 4'h2
`define EAP_WIDE_FIELDS 4'h3
`define EAP_WIDE_AREA 8'h18
`define EAP_BODY_SHARED_SD 8'h0C
`define EAP_BODY_SHARED_IDX 4'h4

`define EAP_CLK_NS 40
`define EAP_TICK_NS 1000
`define EAP_USEC_MAX 20'hF_423F

`endif

// File: common/eap_pkg.sv
// types of the aiding packet codec
package eap_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_RX = 6'b000010,
    S_DEC = 6'b000100,
    S_TXF = 6'b001000,
    S_TXL = 6'b010000,
    S_TXW = 6'b100000
  } eap_state_t;
endpackage : eap_pkg

// File: logic/eap_mem.sv
// payload byte store with registered read data
`timescale 1ns/1ns
module eap_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] store [0:(2**AW)-1];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end
endmodule : eap_mem

// File: test/eap_codec_props.sv
// port assertions of the aiding packet codec
`timescale 1ns/1ns
`include "eap_map.svh"
module eap_codec_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic rxStart,
  input wire logic [7:0] rxId,
  input wire logic reqReady,
  input wire logic rxDrop,
  input wire logic fieldValid,
  input wire logic [7:0] fieldPkt,
  input wire logic [3:0] fieldIdx,
  input wire logic [63:0] fieldData,
  input wire logic fieldWide,
  input wire logic reqValid,
  input wire logic [7:0] reqId,
  input wire logic reqNak,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  input wire logic txReady,
  input wire logic [31:0] runUsec
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_bad_id; rxStart && reqReady && rxId == `EAP_ID_RUNTIME |=> rxDrop; endproperty
  a_bad_id: assert property (p_bad_id) else $error("read-only write not refused");
  property p_wide44; fieldValid && fieldPkt == `EAP_ID_POSVEL |-> fieldWide == (fieldIdx < 4'h3); endproperty
  a_wide44: assert property (p_wide44) else $error("posvel field width");
  property p_wide45; fieldValid && fieldPkt == `EAP_ID_POS |-> fieldWide == (fieldIdx < 4'h3); endproperty
  a_wide45: assert property (p_wide45) else $error("pos field width");
  property p_narrow;
    fieldValid && fieldPkt inside {`EAP_ID_VEL, `EAP_ID_BODYVEL, `EAP_ID_HEADING} |->
      !fieldWide && fieldData[63:32] == 32'h0000_0000;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow field not narrow");
  property p_head_idx; fieldValid && fieldPkt == `EAP_ID_HEADING |-> fieldIdx < 4'h2; endproperty
  a_head_idx: assert property (p_head_idx) else $error("heading field index");
  property p_usec_step;
    $changed(runUsec) |-> runUsec == $past(runUsec) + 1 || (runUsec == 0 && $past(runUsec) == 32'h000F_423F);
  endproperty
  a_usec_step: assert property (p_usec_step) else $error("microsecond step");
  property p_usec_max; runUsec <= 32'h000F_423F; endproperty
  a_usec_max: assert property (p_usec_max) else $error("microseconds out of range");
  property p_tx_hold; txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte not held");
  property p_rt_ans; reqValid && reqReady && !rxStart && reqId == `EAP_ID_RUNTIME |-> ##[1:4] txValid; endproperty
  a_rt_ans: assert property (p_rt_ans) else $error("running time not answered");
  property p_nak; reqValid && reqReady && !rxStart && reqId == 8'h32 |-> ##[1:2] reqNak; endproperty
  a_nak: assert property (p_nak) else $error("foreign id not refused");
endmodule : eap_codec_props
bind eap_codec eap_codec_props i_props (.core_clk, .nrst, .rxStart, .rxId, .reqReady, .rxDrop, .fieldValid,
  .fieldPkt, .fieldIdx, .fieldData, .fieldWide, .reqValid, .reqId, .reqNak, .txValid, .txData, .txLast,
  .txReady, .runUsec);

// File: test/eap_host_model.sv
// host side sink for the codec read answers
`timescale 1ns/1ns
module eap_host_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady
);
  logic [7:0] got[$];
  int lastAt;
  logic [1:0] phase;
  // slow host accepts one beat in four
  assign txReady = !slow || phase == 2'h3;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
      if (txValid && txReady) begin
        // index of the byte that carried the end marker
        if (txLast) lastAt <= got.size();
        got.push_back(txData);
      end
    end
  end
endmodule : eap_host_model

// File: test/test_external_aiding_packet_codec.sv
// self-checking bench of the aiding packet codec
`timescale 1ns/1ns
`include "eap_map.svh"
module test_external_aiding_packet_codec;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic rxStart = 1'b0, rxValid = 1'b0, reqValid = 1'b0, slow = 1'b0;
  logic [7:0] rxId = 8'h00, rxLen = 8'h00, rxData = 8'h00, reqId = 8'h00;
  logic rxDrop, fieldValid, fieldWide, reqReady, reqNak, txValid, txLast, txReady;
  logic [7:0] fieldPkt, txData;
  logic [3:0] fieldIdx;
  logic [63:0] fieldData;
  logic [31:0] runSec, runUsec;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  eap_codec i_dut (.core_clk, .nrst, .rxStart, .rxId, .rxLen, .rxValid, .rxData, .rxDrop, .fieldValid,
    .fieldPkt, .fieldIdx, .fieldData, .fieldWide, .reqValid, .reqId, .reqReady, .reqNak, .txValid, .txData,
    .txLast, .txReady, .runSec, .runUsec);
  eap_host_model i_host (.core_clk, .nrst, .slow, .txValid, .txData, .txLast, .txReady);
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= nrst ? cyc + 1 : 0;
  // top bit clear keeps every float positive
  function automatic logic [7:0] pat(logic [7:0] id, int i);
    return {1'b0, 7'(id + i * 5)};
  endfunction : pat
  task automatic chk(string n, logic [79:0] e, logic [79:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic wr(logic [7:0] id, logic [7:0] len, int nf);
    int off, w, t;
    logic [63:0] e;
    while (reqReady !== 1'b1) @(posedge core_clk);
    {rxStart, rxId, rxLen} <= {1'b1, id, len};
    @(posedge core_clk);
    rxStart <= 1'b0;
    for (int i = 0; i < len; i++) begin
      {rxValid, rxData} <= {1'b1, pat(id, i)};
      @(posedge core_clk);
    end
    rxValid <= 1'b0;
    for (int k = 0; k < nf; k++) begin
      @(posedge core_clk);
      for (t = 0; fieldValid !== 1'b1 && t < 60; t++) @(posedge core_clk);
      w = (k < 3 && id < `EAP_ID_VEL) ? 8 : 4;
      off = (id < `EAP_ID_VEL && k >= 3) ? 24 + 4 * (k - 3) : w * k;
      if (id == `EAP_ID_BODYVEL && len == `EAP_LEN_BODY_SHORT && k > 3) off = 12;
      e = 64'h0000_0000_0000_0000;
      for (int b = 0; b < w; b++) e[8*b +: 8] = pat(id, off + b);
      chk("field", {e, id, 4'(k), w == 8, 3'h0}, {fieldData, fieldPkt, fieldIdx, fieldWide, 3'h0});
    end
  endtask : wr
  task automatic rd(logic [7:0] id, int n, output logic [63:0] q);
    i_host.got.delete();
    i_host.lastAt = -1;
    while (reqReady !== 1'b1) @(posedge core_clk);
    {reqValid, reqId} <= {1'b1, id};
    @(posedge core_clk);
    reqValid <= 1'b0;
    for (int t = 0; i_host.got.size() < n && t < 300; t++) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    chk("tx count", n, i_host.got.size());
    chk("tx last", n - 1, i_host.lastAt);
    for (int i = 0; i < i_host.got.size() && i < 8; i++) q[8*i +: 8] = i_host.got[i];
    if (id != `EAP_ID_RUNTIME) begin
      for (int i = 0; i < i_host.got.size(); i++) chk("tx byte", pat(id, i), i_host.got[i]);
    end
  endtask : rd
  task automatic refuse(logic isRead, logic [7:0] id, logic [7:0] len);
    logic seen;
    seen = 1'b0;
    while (reqReady !== 1'b1) @(posedge core_clk);
    {reqValid, reqId, rxStart, rxId, rxLen} <= {isRead, id, !isRead, id, len};
    @(posedge core_clk);
    {reqValid, rxStart} <= 2'b00;
    repeat (4) begin
      @(posedge core_clk);
      seen |= (isRead ? reqNak : rxDrop) === 1'b1;
    end
    chk("refusal", 1, seen);
  endtask : refuse
  task automatic t_refuse();
    refuse(1, `EAP_ID_VEL, 0);
    refuse(0, `EAP_ID_BODYVEL, 8'h14);
    refuse(1, `EAP_ID_BODYVEL, 0);
    refuse(0, `EAP_ID_RUNTIME, `EAP_LEN_RUNTIME);
    refuse(0, `EAP_ID_POS, `EAP_LEN_VEL);
    refuse(1, 8'h32, 0);
  endtask : t_refuse
  task automatic t_decode();
    wr(`EAP_ID_POSVEL, `EAP_LEN_POSVEL, 12);
    wr(`EAP_ID_POS, `EAP_LEN_POS, 6);
    wr(`EAP_ID_VEL, `EAP_LEN_VEL, 6);
    wr(`EAP_ID_HEADING, `EAP_LEN_HEADING, 2);
  endtask : t_decode
  task automatic t_body();
    logic [63:0] q;
    wr(`EAP_ID_BODYVEL, `EAP_LEN_BODY_SHORT, 6);
    rd(`EAP_ID_BODYVEL, 16, q);
    wr(`EAP_ID_BODYVEL, `EAP_LEN_BODY_LONG, 6);
  endtask : t_body
  task automatic t_readback();
    logic [63:0] q;
    slow <= 1'b1;
    rd(`EAP_ID_HEADING, 8, q);
    slow <= 1'b0;
    rd(`EAP_ID_POSVEL, 60, q);
  endtask : t_readback
  // a new start inside a packet cuts it and leaves the type unwritten
  task automatic t_cut();
    while (reqReady !== 1'b1) @(posedge core_clk);
    {rxStart, rxId, rxLen} <= {1'b1, `EAP_ID_HEADING, `EAP_LEN_HEADING};
    @(posedge core_clk);
    {rxStart, rxValid, rxData} <= {1'b0, 1'b1, 8'h11};
    @(posedge core_clk);
    {rxStart, rxValid} <= 2'b10;
    @(posedge core_clk);
    rxStart <= 1'b0;
    @(posedge core_clk);
    chk("cut drop", 1, rxDrop);
    refuse(1, `EAP_ID_HEADING, 0);
  endtask : t_cut
  task automatic t_time();
    int c0;
    logic [63:0] q;
    c0 = cyc;
    rd(`EAP_ID_RUNTIME, 8, q);
    chk("seconds", 0, q[31:0]);
    chk("usec range", 1, q[63:32] + 1 >= c0 / 25 && q[63:32] <= c0 / 25 + 2);
  endtask : t_time
  task automatic t_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (50) @(posedge core_clk);
    chk("runSec", 0, runSec);
    chk("runUsec low", 1, runUsec <= 3);
    refuse(1, `EAP_ID_HEADING, 0);
  endtask : t_reset
  task automatic summarize();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_refuse();
    t_decode();
    t_body();
    t_readback();
    t_cut();
    t_time();
    t_reset();
    summarize();
  end
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
endmodule : test_external_aiding_packet_codec
